// File: include/nibble_ops_consts.svh
// Purpose: Constants for the nibble-exchange and skip-on-zero execution block
// Assumes: 8-bit data path, 8-bit status register
// Notes:   Opcode encodings are local to this block
`ifndef NIBBLE_OPS_CONSTS_SVH
`define NIBBLE_OPS_CONSTS_SVH

`define DATA_W          8
`define ADDR_W_DEF      7
`define NIB_HI_MSB      7
`define NIB_HI_LSB      4
`define NIB_LO_MSB      3
`define NIB_LO_LSB      0
`define BYTE_ZERO       8'h00
`define ACC_RST         8'h00
`define STATUS_RST      8'h00
`define ADDR_RST        7'h00

`endif

// File: include/nibble_ops_pkg.sv
// Purpose: Types for the nibble-exchange and skip-on-zero execution block
// Assumes: Included constants header defines widths
// Notes:   Command codes take encodings 0 to 4 from declaration order
`include "nibble_ops_consts.svh"

package nibble_ops_pkg;

   typedef enum logic [2:0] {
      op_none,
      op_nibble_exchange_in_place,
      op_nibble_exchange_to_accumulator,
      op_skip_when_byte_zero,
      op_load_then_skip_when_zero
   } op_t;

   // Status flags in register bit order, msb first
   typedef struct packed {
      logic test_condition_two_flag;
      logic test_condition_one_flag;
      logic timeout_flag;
      logic power_down_flag;
      logic overflow_flag;
      logic zero_flag;
      logic auxiliary_carry_flag;
      logic carry_flag;
   } status_t;

   // Memory write request
   typedef struct packed {
      logic                    en;
      logic [`ADDR_W_DEF-1:0]  addr;
      logic [`DATA_W-1:0]      data;
   } mem_wr_t;

endpackage : nibble_ops_pkg

// File: hw/nibble_ops.sv
// Purpose: Executes nibble exchange and skip-on-zero instructions of the core
// Assumes: Operand byte arrives with the issue strobe; fetch honours discard
// Notes:   One issue per cycle; a taken skip adds one dummy cycle
//
// Overview of operation
// - In-place exchange swaps byte nibbles and writes result to same address.
// - In-place exchange leaves every status flag unchanged.
// - Exchange-to-accumulator loads swapped byte into accumulator, memory untouched.
// - Skip-when-zero discards prefetched instruction, inserts dummy cycle if byte zero.
// - Load-then-skip copies byte to accumulator, skips likewise when byte zero.
`timescale 1ns/1ps
`default_nettype none
`include "nibble_ops_consts.svh"

module nibble_ops
   import nibble_ops_pkg::*;
#(
   parameter int ADDR_W = `ADDR_W_DEF
) (
   // Clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 nrst_i,
   // Instruction issue from decoder
   input  wire logic                 issue_i,
   input  wire op_t                  op_i,
   input  wire logic [ADDR_W-1:0]    addr_i,
   input  wire logic [`DATA_W-1:0]   mem_rd_data_i,
   // Status register of the core
   input  wire status_t              status_i,
   // Results
   output var  mem_wr_t              mem_wr_o,
   output var  logic [`DATA_W-1:0]   acc_o,
   output var  logic                 acc_wr_o,
   output var  status_t              status_o,
   output var  logic                 status_wr_o,
   // Fetch control
   output var  logic                 discard_o,
   output var  logic                 dummy_o,
   output var  logic                 busy_o
);

   // -------------------------------------------------------------------
   // Local types
   // -------------------------------------------------------------------
   typedef enum logic {
      st_exec,
      st_dummy
   } state_t;

   // -------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------
   // Upper and lower nibbles trade places
   function automatic logic [`DATA_W-1:0] nib_swap(
      input logic [`DATA_W-1:0] b
   );
      nib_swap = {b[`NIB_LO_MSB:`NIB_LO_LSB], b[`NIB_HI_MSB:`NIB_HI_LSB]};
   endfunction : nib_swap

   // Zero test covers the whole byte
   function automatic logic is_zero_byte(
      input logic [`DATA_W-1:0] b
   );
      is_zero_byte = (b == `BYTE_ZERO);
   endfunction : is_zero_byte

   // Commands that may drop the prefetched word
   function automatic logic is_skip_op(
      input op_t op
   );
      is_skip_op = (op == op_skip_when_byte_zero) ||
                   (op == op_load_then_skip_when_zero);
   endfunction : is_skip_op

   // Commands that load the accumulator
   function automatic logic is_acc_op(
      input op_t op
   );
      is_acc_op = (op == op_nibble_exchange_to_accumulator) ||
                  (op == op_load_then_skip_when_zero);
   endfunction : is_acc_op

   // Accumulator value for an accumulator command
   function automatic logic [`DATA_W-1:0] acc_value(
      input op_t                op,
      input logic [`DATA_W-1:0] b
   );
      if (op == op_nibble_exchange_to_accumulator) begin
         acc_value = nib_swap(b);
      end else begin
         acc_value = b;
      end
   endfunction : acc_value

   // -------------------------------------------------------------------
   // Internal signals
   // -------------------------------------------------------------------
   state_t             state_reg;
   state_t             state_next;
   logic               accept;
   logic               byte_zero;
   logic               skip_taken;
   logic               swap_wr;
   logic               acc_load;
   logic [`DATA_W-1:0] acc_reg;

   // -------------------------------------------------------------------
   // Issue decode
   // -------------------------------------------------------------------
   // No instruction is taken during the dummy cycle
   assign accept     = issue_i && (state_reg == st_exec);
   assign byte_zero  = is_zero_byte(mem_rd_data_i);
   assign skip_taken = accept && byte_zero && is_skip_op(op_i);
   assign swap_wr    = accept && (op_i == op_nibble_exchange_in_place);
   assign acc_load   = accept && is_acc_op(op_i);

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         st_exec: begin
            if (skip_taken) begin
               state_next = st_dummy;
            end
         end
         st_dummy: begin
            state_next = st_exec;
         end
         default: begin
            state_next = st_exec;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state_reg <= st_exec;
      end else begin
         state_reg <= state_next;
      end
   end

   // High for the whole dummy cycle
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         busy_o <= 1'h0;
      end else begin
         busy_o <= (state_next == st_dummy);
      end
   end

   // Tells fetch to drop the prefetched word
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         discard_o <= 1'h0;
      end else begin
         discard_o <= skip_taken;
      end
   end

   // Marks the inserted dummy cycle
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         dummy_o <= 1'h0;
      end else begin
         dummy_o <= skip_taken;
      end
   end

   // -------------------------------------------------------------------
   // Data memory write-back
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         mem_wr_o <= '{en: 1'h0, addr: `ADDR_RST, data: `BYTE_ZERO};
      end else begin
         mem_wr_o.en <= swap_wr;
         if (swap_wr) begin
            mem_wr_o.addr <= addr_i;
            mem_wr_o.data <= nib_swap(mem_rd_data_i);
         end
      end
   end

   // -------------------------------------------------------------------
   // Accumulator
   // -------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         acc_reg <= `ACC_RST;
      end else if (acc_load) begin
         acc_reg <= acc_value(op_i, mem_rd_data_i);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         acc_wr_o <= 1'h0;
      end else begin
         acc_wr_o <= acc_load;
      end
   end

   assign acc_o = acc_reg;

   // -------------------------------------------------------------------
   // Status pass-through
   // -------------------------------------------------------------------
   // None of these instructions alters a flag, so no status write occurs
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         status_o <= `STATUS_RST;
      end else begin
         status_o <= status_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         status_wr_o <= 1'h0;
      end else begin
         status_wr_o <= 1'h0;
      end
   end

endmodule : nibble_ops
`default_nettype wire

// File: testbench/nibble_ops_chk.sv
// Purpose: Checker for the nibble exchange and skip-on-zero block
// Assumes: Sees only the ports of nibble_ops
// Notes:   Bound into every instance
`timescale 1ns/1ps
`default_nettype none
module nibble_ops_chk
   import nibble_ops_pkg::*;
#(
   parameter int ADDR_W = 7
) (
   // Clock and reset
   input wire logic              clk_sys_i,
   input wire logic              nrst_i,
   // Issue side
   input wire logic              issue_i,
   input wire op_t               op_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [7:0]        mem_rd_data_i,
   input wire status_t           status_i,
   // Results
   input wire mem_wr_t           mem_wr_o,
   input wire logic [7:0]        acc_o,
   input wire logic              acc_wr_o,
   input wire status_t           status_o,
   input wire logic              status_wr_o,
   // Fetch control
   input wire logic              discard_o,
   input wire logic              dummy_o,
   input wire logic              busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   wire logic tk = issue_i && !busy_o;
   wire logic [7:0] sw = {mem_rd_data_i[3:0], mem_rd_data_i[7:4]};
   wire logic nz = mem_rd_data_i != 8'h00;
   wire logic sk = op_i == op_skip_when_byte_zero || op_i == op_load_then_skip_when_zero;
   sequence skip_s; discard_o && dummy_o && busy_o ##1 !busy_o; endsequence
   a_swap_in_place:
      assert property (tk && op_i == op_nibble_exchange_in_place |=> mem_wr_o.en
         && mem_wr_o.data == $past(sw) && mem_wr_o.addr == $past(addr_i)) else $error("bad in-place swap");
   a_flags_kept:
      assert property (tk && op_i == op_nibble_exchange_in_place |=> !status_wr_o
         && status_o == $past(status_i)) else $error("flags changed");
   a_swap_to_acc:
      assert property (tk && op_i == op_nibble_exchange_to_accumulator |=> acc_wr_o
         && acc_o == $past(sw) && !mem_wr_o.en) else $error("bad swap to acc");
   a_skip_taken:
      assert property (tk && sk && !nz |=> skip_s) else $error("skip not taken");
   a_skip_not_taken:
      assert property (tk && sk && nz |=> !discard_o && !dummy_o && !busy_o) else $error("wrong skip");
   a_load_acc:
      assert property (tk && op_i == op_load_then_skip_when_zero |=> acc_wr_o
         && acc_o == $past(mem_rd_data_i)) else $error("bad load");
   a_dummy_quiet:
      assert property (busy_o |=> !mem_wr_o.en && !acc_wr_o && !discard_o) else $error("dummy wrote");
endmodule : nibble_ops_chk
bind nibble_ops nibble_ops_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// File: testbench/nibble_ops_tb_top.sv
// Purpose: Self-checking bench for nibble_ops
// Assumes: One issue per cycle, refused in dummy cycle
// Notes:   Random stimulus from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module nibble_ops_tb_top;
   import nibble_ops_pkg::*;
   logic clk_sys_i = 1'h0, nrst_i = 1'h0, issue_i = 1'h0, acc_wr_o, status_wr_o, discard_o, dummy_o, busy_o;
   op_t op_i = op_none;
   logic [6:0] addr_i = 7'h00;
   logic [7:0] mem_rd_data_i = 8'h00, acc_o, ae = 8'h00;
   status_t status_i = 8'h00, status_o;
   mem_wr_t mem_wr_o;
   int n_mismatch = 0, tests_run = 0;
   logic [31:0] rng = 32'h4085;
   nibble_ops DUT (.*);
   initial forever #5 clk_sys_i = ~clk_sys_i;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13; x ^= x >> 17; x ^= x << 5;
      return x;
   endfunction : xs
   function automatic logic [7:0] exp_swap(input logic [7:0] b);
      return {b[3:0], b[7:4]};
   endfunction : exp_swap
   function automatic logic exp_skip(input op_t o, input logic [7:0] b);
      return b == 8'h00 && (o == op_skip_when_byte_zero || o == op_load_then_skip_when_zero);
   endfunction : exp_skip
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_flag(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL %s exp %b got %b", nm, e, g);
      end
   endtask : chk_flag
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task automatic run(input op_t o, input logic [7:0] d);
      logic z;
      logic aw;
      z = exp_skip(o, d);
      aw = o == op_nibble_exchange_to_accumulator || o == op_load_then_skip_when_zero;
      rng = xs(rng);
      op_i = o;
      mem_rd_data_i = d;
      addr_i = rng[6:0];
      status_i = rng[15:8];
      issue_i = 1'h1;
      if (o == op_nibble_exchange_to_accumulator) ae = exp_swap(d);
      if (o == op_load_then_skip_when_zero) ae = d;
      @(negedge clk_sys_i);
      chk_flag("mem_en", o == op_nibble_exchange_in_place, mem_wr_o.en);
      if (o == op_nibble_exchange_in_place) chk("mem_data", exp_swap(d), mem_wr_o.data);
      if (o == op_nibble_exchange_in_place) chk("mem_addr", {1'h0, addr_i}, {1'h0, mem_wr_o.addr});
      chk("status", status_i, status_o);
      chk_flag("status_wr", 1'h0, status_wr_o);
      chk_flag("acc_wr", aw, acc_wr_o);
      chk("acc", ae, acc_o);
      chk_flag("discard", z, discard_o);
      chk_flag("dummy", z, dummy_o);
      chk_flag("busy", z, busy_o);
      if (z) begin
         rng = xs(rng);
         op_i = rng[0] ? op_nibble_exchange_in_place : op_load_then_skip_when_zero;
         @(negedge clk_sys_i);
         chk_flag("dummy_mem", 1'h0, mem_wr_o.en);
         chk_flag("dummy_acc", 1'h0, acc_wr_o);
         chk_flag("dummy_skip", 1'h0, discard_o);
         chk_flag("dummy_end", 1'h0, busy_o);
      end
   endtask : run
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (12) @(negedge clk_sys_i);
      nrst_i = 1'h1;
      chk("acc_rst", 8'h00, acc_o);
      for (int i = 0; i < 15; i++) run(op_t'(3'(i % 5)), i < 5 ? 8'h00 : i < 10 ? 8'hff : 8'h5a);
      repeat (300) begin
         rng = xs(rng);
         run(op_t'(rng[18:16] % 3'h5), rng[21:20] == 2'h0 ? 8'h00 : rng[31:24]);
      end
      test_done();
   end
endmodule : nibble_ops_tb_top
`default_nettype wire
